// ### hw/wdu_watchdog_unit.v
// Function
// - reset on underflow only if reset-enable set
// - timer runs after any reset
// - run bit starts/stops timer, reset value one
// - timer mode raises enabled interrupt on underflow
// - 13-bit prescaler, 8-bit down counter on tap
// - prescaler source selectable, change may lag
// - watchdog reset asserted on enabled underflow
// - reset lasts at least one watchdog clock
// - powered-down reset restarts oscillator, waits stable
// - reset-enable zero disables reset, ignores safety
// - reset enabled, software picks clock source
// - both set: force osc, run; write-once
// - writes held until valid feed loads them
// - writes between feed writes break sequence
// - wrong feed sequence resets at once
// - watchdog mode control write needs immediate feed
// - timer mode control follows holding every cycle
// - timeout 2^(5+pre)*(load+1)+1 watchdog clocks
// - prescaler select 0..7, load 0..255
// - flag set on underflow, zero write or watchdog-mode feed clears
// - select one oscillator, zero peripheral clock
//
// Purpose: watchdog unit with feed sequence behind an AXI4-Lite slave
// Assumes: pclk_en_in is a one-cycle enable on clk_in; oscillator and
//   oscillator-stable inputs are asynchronous pins
// Notes: the unit itself is cleared only by resetn_in (power-on)
//
// Decided for this implementation: the AXI4-Lite register port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wdu_regs.vh"

module wdu_watchdog_unit (
  input wire clk_in,
  input wire resetn_in,
  input wire pclk_en_in,
  input wire wdosc_in,
  input wire reset_on_underflow_enable_in,
  input wire safety_lock_enable_in,
  input wire powered_down_in,
  input wire osc_stable_in,
  input wire interrupt_enable_in,
  input wire s_axi_awvalid_in,
  output wire s_axi_awready_out,
  input wire [7:0] s_axi_awaddr_in,
  input wire s_axi_wvalid_in,
  output wire s_axi_wready_out,
  input wire [31:0] s_axi_wdata_in,
  input wire [3:0] s_axi_wstrb_in,
  output wire s_axi_bvalid_out,
  input wire s_axi_bready_in,
  output wire [1:0] s_axi_bresp_out,
  input wire s_axi_arvalid_in,
  output wire s_axi_arready_out,
  input wire [7:0] s_axi_araddr_in,
  output wire s_axi_rvalid_out,
  input wire s_axi_rready_in,
  output wire [31:0] s_axi_rdata_out,
  output wire [1:0] s_axi_rresp_out,
  output wire wd_reset_out,
  output wire osc_start_out,
  output wire irq_out,
  output wire timeout_flag_out
);

////////////////////////////////////////////////////////////////////////////
// functions

// map a byte address onto a register index
function [2:0] reg_index;
  input [7:0] addr;
  begin
    case (addr)
      `WDU_OFF_CTRL: reg_index = `WDU_IDX_CTRL;
      `WDU_OFF_RELOAD: reg_index = `WDU_IDX_RELOAD;
      `WDU_OFF_FEED1: reg_index = `WDU_IDX_FEED1;
      `WDU_OFF_FEED2: reg_index = `WDU_IDX_FEED2;
      `WDU_OFF_STATUS: reg_index = `WDU_IDX_STATUS;
      default: reg_index = `WDU_IDX_NONE;
    endcase
  end
endfunction

// true when the prescaler sits on the last count of the selected tap
function tap_end;
  input [2:0] pre;
  input [`WDU_PRE_W-1:0] cnt;
  reg [`WDU_PRE_W-1:0] m;
  begin
    m = (13'h0001 << ({1'b0, pre} + `WDU_PRE_BASE)) - 13'h0001;
    tap_end = ((cnt & m) == m);
  end
endfunction

////////////////////////////////////////////////////////////////////////////
// pin synchronisers: only the second stage reads the first

reg osc_s1_ff, osc_s2_ff, osc_s3_ff, osc_lvl_ff;
reg stb_s1_ff, stb_s2_ff, stb_s3_ff, stb_lvl_ff;
wire osc_tick;

// a change counts once stages two and three agree
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    osc_s1_ff <= 1'b0;
    osc_s2_ff <= 1'b0;
    osc_s3_ff <= 1'b0;
    osc_lvl_ff <= 1'b0;
    stb_s1_ff <= 1'b0;
    stb_s2_ff <= 1'b0;
    stb_s3_ff <= 1'b0;
    stb_lvl_ff <= 1'b0;
  end else begin
    osc_s1_ff <= wdosc_in;
    osc_s2_ff <= osc_s1_ff;
    osc_s3_ff <= osc_s2_ff;
    if (osc_s2_ff == osc_s3_ff) begin
      osc_lvl_ff <= osc_s3_ff;
    end
    stb_s1_ff <= osc_stable_in;
    stb_s2_ff <= stb_s1_ff;
    stb_s3_ff <= stb_s2_ff;
    if (stb_s2_ff == stb_s3_ff) begin
      stb_lvl_ff <= stb_s3_ff;
    end
  end
end

// one tick per filtered rising edge of the oscillator
assign osc_tick = (osc_s2_ff == osc_s3_ff) & osc_s3_ff & ~osc_lvl_ff;

////////////////////////////////////////////////////////////////////////////
// configuration word, caught after reset release

reg cfg_done_ff, cfg_rst_en_ff, cfg_safe_ff;
wire wd_mode, lock;

always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    cfg_done_ff <= 1'b0;
    cfg_rst_en_ff <= 1'b0;
    cfg_safe_ff <= 1'b0;
  end else if (!cfg_done_ff) begin
    cfg_done_ff <= 1'b1;
    cfg_rst_en_ff <= reset_on_underflow_enable_in;
    cfg_safe_ff <= safety_lock_enable_in;
  end
end

assign wd_mode = cfg_rst_en_ff;
// safety only counts with reset enabled
assign lock = cfg_rst_en_ff & cfg_safe_ff;

////////////////////////////////////////////////////////////////////////////
// AXI4-Lite slave handshake

reg aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
reg [7:0] awaddr_ff;
reg [31:0] wdata_ff, rdata_ff;
reg [3:0] wstrb_ff;
reg [1:0] bresp_ff, rresp_ff;
wire do_write, do_read, wr_en;
wire [2:0] wr_idx, rd_idx;
wire [7:0] wbyte;
reg [31:0] nxt_rdata;

assign s_axi_awready_out = ~aw_got_ff & ~bvalid_ff;
assign s_axi_wready_out = ~w_got_ff & ~bvalid_ff;
assign s_axi_bvalid_out = bvalid_ff;
assign s_axi_bresp_out = bresp_ff;
assign s_axi_arready_out = ~rvalid_ff;
assign s_axi_rvalid_out = rvalid_ff;
assign s_axi_rdata_out = rdata_ff;
assign s_axi_rresp_out = rresp_ff;

assign do_write = aw_got_ff & w_got_ff;
assign wr_idx = reg_index(awaddr_ff);
assign wbyte = wdata_ff[7:0];
// only the low lane holds register bits; a write without it is dropped
assign wr_en = do_write & wstrb_ff[0] & (wr_idx != `WDU_IDX_NONE);
assign do_read = s_axi_arvalid_in & ~rvalid_ff;
assign rd_idx = reg_index(s_axi_araddr_in);

// address and data are taken in either order, answered once both are in
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    aw_got_ff <= 1'b0;
    w_got_ff <= 1'b0;
    awaddr_ff <= 8'h00;
    wdata_ff <= 32'h0000_0000;
    wstrb_ff <= 4'h0;
    bvalid_ff <= 1'b0;
    bresp_ff <= `WDU_RESP_OKAY;
  end else begin
    if (s_axi_awvalid_in & s_axi_awready_out) begin
      aw_got_ff <= 1'b1;
      awaddr_ff <= s_axi_awaddr_in;
    end
    if (s_axi_wvalid_in & s_axi_wready_out) begin
      w_got_ff <= 1'b1;
      wdata_ff <= s_axi_wdata_in;
      wstrb_ff <= s_axi_wstrb_in;
    end
    if (do_write) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b1;
      bresp_ff <= (wr_idx == `WDU_IDX_NONE) ? `WDU_RESP_SLVERR
                                            : `WDU_RESP_OKAY;
    end else if (bvalid_ff & s_axi_bready_in) begin
      bvalid_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// holding registers, active control and feed detector

reg [7:0] hold_ctrl_ff, hold_reload_ff;
reg [2:0] act_pre_ff;
reg act_run_ff, act_sel_ff, flag_ff;
reg ctrl_once_ff, reload_once_ff;
reg armed_ff, ctrl_pend_ff, feed_err_ff;
reg [7:0] cnt_ff;
reg [`WDU_PRE_W-1:0] presc_ff;
reg expire_ff, rst_active_ff, osc_restart_ff;
reg [1:0] rst_ticks_ff;
reg feed_ok, feed_bad;
wire eff_run, eff_sel, tick, underflow, trigger, rst_done;

// safety lock overrides source and run bits
assign eff_sel = lock ? 1'b1 : act_sel_ff;
assign eff_run = lock ? 1'b1 : act_run_ff;
// new source is only seen at the next tick of that source
assign tick = eff_sel ? osc_tick : pclk_en_in;
assign underflow = tick & eff_run & ~rst_active_ff & expire_ff;
// errors and underflow only reset in watchdog mode
assign trigger = wd_mode & (underflow | feed_bad);
assign rst_done = rst_active_ff & tick & (rst_ticks_ff == `WDU_RST_TICKS);

// classify each register write against the feed sequence
always @* begin
  feed_ok = 1'b0;
  feed_bad = 1'b0;
  if (wr_en) begin
    if (armed_ff) begin
      // any write other than the second key breaks the sequence
      if ((wr_idx == `WDU_IDX_FEED2) && (wbyte == `WDU_FEED2_KEY)) begin
        feed_ok = 1'b1;
      end else begin
        feed_bad = 1'b1;
      end
    end else if (ctrl_pend_ff) begin
      if ((wr_idx != `WDU_IDX_FEED1) || (wbyte != `WDU_FEED1_KEY)) begin
        feed_bad = 1'b1;
      end
    end else if ((wr_idx == `WDU_IDX_FEED1) &&
                 (wbyte != `WDU_FEED1_KEY)) begin
      feed_bad = 1'b1;
    end else if (wr_idx == `WDU_IDX_FEED2) begin
      feed_bad = 1'b1;
    end
  end
end

// software view of control and reload, plus feed state
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    hold_ctrl_ff <= `WDU_CTRL_RST;
    hold_reload_ff <= `WDU_RELOAD_RST;
    ctrl_once_ff <= 1'b0;
    reload_once_ff <= 1'b0;
    armed_ff <= 1'b0;
    ctrl_pend_ff <= 1'b0;
    feed_err_ff <= 1'b0;
  end else begin
    if (wr_en && (wr_idx == `WDU_IDX_CTRL) && !(lock && ctrl_once_ff)) begin
      hold_ctrl_ff <= wbyte;
      ctrl_once_ff <= 1'b1;
    end
    if (wr_en && (wr_idx == `WDU_IDX_RELOAD) &&
        !(lock && reload_once_ff)) begin
      hold_reload_ff <= wbyte;
      reload_once_ff <= 1'b1;
    end
    if (rst_done) begin
      hold_ctrl_ff[`WDU_CTRL_RUN] <= 1'b1;
    end
    // arm only on a good first key written outside any sequence
    if (wr_en) begin
      armed_ff <= ~armed_ff & (wr_idx == `WDU_IDX_FEED1) &
                  (wbyte == `WDU_FEED1_KEY);
    end
    if (feed_ok | feed_bad) begin
      ctrl_pend_ff <= 1'b0;
    end else if (wr_en && wd_mode && (wr_idx == `WDU_IDX_CTRL)) begin
      ctrl_pend_ff <= 1'b1;
    end
    if (feed_bad) begin
      feed_err_ff <= 1'b1;
    end else if (feed_ok) begin
      feed_err_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// prescaler, down counter, timeout flag

always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    act_pre_ff <= `WDU_CTRL_PRE_RST;
    act_run_ff <= 1'b1;
    act_sel_ff <= 1'b1;
    cnt_ff <= `WDU_RELOAD_RST;
    presc_ff <= {`WDU_PRE_W{1'b0}};
    expire_ff <= 1'b0;
    flag_ff <= 1'b0;
  end else begin
    // timer mode: control follows the holding copy every cycle
    if (!wd_mode || feed_ok) begin
      act_pre_ff <= hold_ctrl_ff[`WDU_CTRL_PRE_HI:`WDU_CTRL_PRE_LO];
      act_run_ff <= hold_ctrl_ff[`WDU_CTRL_RUN];
      act_sel_ff <= hold_ctrl_ff[`WDU_CTRL_SEL];
    end
    if (feed_ok || rst_done) begin
      cnt_ff <= hold_reload_ff;
      presc_ff <= {`WDU_PRE_W{1'b0}};
      expire_ff <= 1'b0;
      if (rst_done) begin
        act_run_ff <= 1'b1;
      end
    end else if (tick && eff_run && !rst_active_ff) begin
      if (expire_ff) begin
        // the extra tick after the last tap gives the +1
        expire_ff <= 1'b0;
        presc_ff <= {`WDU_PRE_W{1'b0}};
        cnt_ff <= `WDU_RELOAD_RST;
      end else if (tap_end(act_pre_ff, presc_ff)) begin
        presc_ff <= {`WDU_PRE_W{1'b0}};
        if (cnt_ff == 8'h00) begin
          expire_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff - 8'h01;
        end
      end else begin
        presc_ff <= presc_ff + 13'h0001;
      end
    end
    // a new underflow wins over a clear in the same cycle
    if (underflow) begin
      flag_ff <= 1'b1;
    end else if (feed_ok && wd_mode) begin
      flag_ff <= 1'b0;
    end else if (wr_en && (wr_idx == `WDU_IDX_CTRL) &&
                 !wbyte[`WDU_CTRL_FLAG]) begin
      flag_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////
// watchdog reset pulse and oscillator restart

// held until a full watchdog clock period has passed
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    rst_active_ff <= 1'b0;
    rst_ticks_ff <= 2'h0;
    osc_restart_ff <= 1'b0;
  end else begin
    if (trigger && !rst_active_ff) begin
      rst_active_ff <= 1'b1;
      rst_ticks_ff <= 2'h0;
      if (powered_down_in) begin
        osc_restart_ff <= 1'b1;
      end
    end else if (rst_done) begin
      rst_active_ff <= 1'b0;
    end else if (rst_active_ff && tick) begin
      rst_ticks_ff <= rst_ticks_ff + 2'h1;
    end
    // execution stays held until the oscillator reports stable
    if (osc_restart_ff && !rst_active_ff && stb_lvl_ff) begin
      osc_restart_ff <= 1'b0;
    end
  end
end

assign wd_reset_out = rst_active_ff | osc_restart_ff;
assign osc_start_out = osc_restart_ff;
assign timeout_flag_out = flag_ff;
// timer mode only; the core gates it with its own interrupt logic
assign irq_out = flag_ff & ~wd_mode & interrupt_enable_in;

////////////////////////////////////////////////////////////////////////////
// read path

always @* begin
  nxt_rdata = 32'h0000_0000;
  case (rd_idx)
    `WDU_IDX_CTRL: begin
      nxt_rdata[7:0] = hold_ctrl_ff;
      nxt_rdata[`WDU_CTRL_FLAG] = flag_ff;
      if (lock) begin
        nxt_rdata[`WDU_CTRL_SEL] = 1'b1;
        nxt_rdata[`WDU_CTRL_RUN] = 1'b1;
      end
    end
    `WDU_IDX_RELOAD: nxt_rdata[7:0] = hold_reload_ff;
    `WDU_IDX_STATUS: begin
      nxt_rdata[`WDU_ST_CNT_HI:`WDU_ST_CNT_LO] = cnt_ff;
      nxt_rdata[`WDU_ST_PRE_HI:`WDU_ST_PRE_LO] = act_pre_ff;
      nxt_rdata[`WDU_ST_RUN] = eff_run;
      nxt_rdata[`WDU_ST_SEL] = eff_sel;
      nxt_rdata[`WDU_ST_ARMED] = armed_ff;
      nxt_rdata[`WDU_ST_FEED_ERR] = feed_err_ff;
      nxt_rdata[`WDU_ST_RST] = rst_active_ff;
      nxt_rdata[`WDU_ST_WD_MODE] = wd_mode;
      nxt_rdata[`WDU_ST_LOCK] = lock;
    end
    default: nxt_rdata = 32'h0000_0000;
  endcase
end

// reads never disturb the feed sequence
always @(posedge clk_in or negedge resetn_in) begin
  if (!resetn_in) begin
    rvalid_ff <= 1'b0;
    rdata_ff <= 32'h0000_0000;
    rresp_ff <= `WDU_RESP_OKAY;
  end else if (do_read) begin
    rvalid_ff <= 1'b1;
    rdata_ff <= nxt_rdata;
    rresp_ff <= (rd_idx == `WDU_IDX_NONE) ? `WDU_RESP_SLVERR
                                          : `WDU_RESP_OKAY;
  end else if (rvalid_ff && s_axi_rready_in) begin
    rvalid_ff <= 1'b0;
  end
end

endmodule // wdu_watchdog_unit
`default_nettype wire

// ### include/wdu_regs.vh
// Purpose: register map, field positions and constants of the watchdog unit
// Assumes: 32-bit AXI4-Lite slave, byte addresses, one word per register
// Notes: definitions only
`ifndef WDU_REGS_VH
`define WDU_REGS_VH

// register byte offsets
`define WDU_OFF_CTRL 8'h00
`define WDU_OFF_RELOAD 8'h04
`define WDU_OFF_FEED1 8'h08
`define WDU_OFF_FEED2 8'h0c
`define WDU_OFF_STATUS 8'h10

// decoded register indices
`define WDU_IDX_CTRL 3'h0
`define WDU_IDX_RELOAD 3'h1
`define WDU_IDX_FEED1 3'h2
`define WDU_IDX_FEED2 3'h3
`define WDU_IDX_STATUS 3'h4
`define WDU_IDX_NONE 3'h7

// control register fields
`define WDU_CTRL_SEL 0
`define WDU_CTRL_FLAG 1
`define WDU_CTRL_RUN 2
`define WDU_CTRL_PRE_LO 5
`define WDU_CTRL_PRE_HI 7
`define WDU_CTRL_RST 8'he5
`define WDU_CTRL_PRE_RST 3'h7
`define WDU_RELOAD_RST 8'hff

// status register fields
`define WDU_ST_CNT_LO 0
`define WDU_ST_CNT_HI 7
`define WDU_ST_PRE_LO 8
`define WDU_ST_PRE_HI 10
`define WDU_ST_RUN 11
`define WDU_ST_SEL 12
`define WDU_ST_ARMED 13
`define WDU_ST_FEED_ERR 14
`define WDU_ST_RST 15
`define WDU_ST_WD_MODE 16
`define WDU_ST_LOCK 17

// feed key values
`define WDU_FEED1_KEY 8'ha5
`define WDU_FEED2_KEY 8'h5a

// timing: tap is 2^(base+pre) prescaler ticks
`define WDU_PRE_BASE 4'h5
`define WDU_PRE_W 13
`define WDU_RST_TICKS 2'h1

// bus answers
`define WDU_RESP_OKAY 2'b00
`define WDU_RESP_SLVERR 2'b10

`endif

// ### verification/watchdog_timer_with_feed_tb.sv
// Purpose: self-checking bench of the watchdog unit
// Assumes: pclk tick every second cycle, bench is the only bus writer
// Notes: config pins change only while the unit is held in reset
`timescale 1ns/1ps
`default_nettype none
`include "wdu_regs.vh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (g), (e)); end end
module watchdog_timer_with_feed_tb;
  logic clk_in = 0, resetn_in = 0, pclk_en_in = 0, rue = 0, sle = 0;
  logic pd = 0, ien = 1, awvalid = 0, wvalid = 0, bready = 0;
  logic arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [31:0] wdata = 0, d, v;
  logic [3:0] wstrb = 0;
  logic [1:0] r;
  wire awready, wready, bvalid, arready, rvalid, wd_rst, osc_start;
  wire irq, flag, wdosc, stable;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  int err_total = 0, n_checks = 0, cyc = 0, t;
  integer seed;
  wdu_watchdog_unit u_wdu_watchdog_unit (.clk_in(clk_in),
    .resetn_in(resetn_in), .pclk_en_in(pclk_en_in), .wdosc_in(wdosc),
    .reset_on_underflow_enable_in(rue), .safety_lock_enable_in(sle),
    .powered_down_in(pd), .osc_stable_in(stable),
    .interrupt_enable_in(ien), .s_axi_awvalid_in(awvalid),
    .s_axi_awready_out(awready), .s_axi_awaddr_in(awaddr),
    .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb),
    .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_bresp_out(bresp), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_araddr_in(araddr),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .wd_reset_out(wd_rst), .osc_start_out(osc_start), .irq_out(irq),
    .timeout_flag_out(flag));
  wdu_osc_model u_wdu_osc_model (.clk_in(clk_in), .resetn_in(resetn_in),
    .osc_start_in(osc_start), .powered_down_in(pd), .wdosc_out(wdosc),
    .osc_stable_out(stable));
  //////////////////////////////////////////////////////////////////////
  initial forever #50 clk_in = ~clk_in;
  // pclk tick plus a hang guard well above the whole run
  always @(posedge clk_in) begin
    pclk_en_in <= ~pclk_en_in;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      results();
    end
  end
  task results;
    $display("checks=%0d errors=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic int tclks(input int pre, input int ld);
    return (1 << (5 + pre)) * (ld + 1) + 1;
  endfunction
  // trailing edge keeps two calls from driving one signal in one step
  task wr(input [7:0] a, input [31:0] x);
    logic aw, w;
    aw = 0;
    w = 0;
    awaddr <= a;
    wdata <= x;
    wstrb <= 4'hf;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!(aw && w)) begin
      @(posedge clk_in);
      if (!aw && awready === 1'b1) begin
        aw = 1;
        awvalid <= 0;
      end
      if (!w && wready === 1'b1) begin
        w = 1;
        wvalid <= 0;
      end
    end
    while (bvalid !== 1'b1) @(posedge clk_in);
    r = bresp;
    bready <= 0;
    @(posedge clk_in);
  endtask
  task rd(input [7:0] a);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    @(posedge clk_in);
    while (arready !== 1'b1) @(posedge clk_in);
    arvalid <= 0;
    @(posedge clk_in);
    while (rvalid !== 1'b1) @(posedge clk_in);
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge clk_in);
  endtask
  // no interrupt source in the bench, so nothing can split the pair
  task feed;
    wr(`WDU_OFF_FEED1, 32'ha5);
    wr(`WDU_OFF_FEED2, 32'h5a);
  endtask
  task wait_rst(input logic lv, input int n);
    for (int i = 0; i < n && wd_rst !== lv; i++) @(posedge clk_in);
    `CHK(wd_rst, lv)
  endtask
  task por(input logic e, input logic s);
    resetn_in <= 0;
    rue <= e;
    sle <= s;
    pd <= 0;
    repeat (10) @(posedge clk_in);
    resetn_in <= 1;
    repeat (2) @(posedge clk_in);
  endtask
  task tick_until_flag;
    t = 0;
    while (flag !== 1'b1) begin
      @(posedge clk_in);
      if (pclk_en_in) t++;
    end
  endtask
  //////////////////////////////////////////////////////////////////////
  initial begin
    seed = 32'he8fcfa68;
    // timer mode: reset values, unmapped place, random settings
    por(0, 0);
    rd(`WDU_OFF_CTRL); `CHK(d[7:0], `WDU_CTRL_RST)
    rd(`WDU_OFF_STATUS); `CHK(d[11], 1'b1)
    rd(8'h14); `CHK(r, `WDU_RESP_SLVERR)
    wr(8'h14, 32'h0); `CHK(r, `WDU_RESP_SLVERR)
    for (int i = 0; i < 6; i++) begin
      v = $random(seed);
      if (i < 2) v[7:5] = i ? 3'h7 : 3'h0;
      wr(`WDU_OFF_RELOAD, v);
      wr(`WDU_OFF_CTRL, {24'h0, v[7:5], 5'h04});
      `CHK(r, `WDU_RESP_OKAY)
      rd(`WDU_OFF_RELOAD); `CHK(d[7:0], v[7:0])
      rd(`WDU_OFF_STATUS); `CHK(d[10:8], v[7:5])
    end
    // shortest timeout on pclk, interrupt, flag clear
    wr(`WDU_OFF_RELOAD, 32'h0);
    wr(`WDU_OFF_CTRL, 32'h04);
    feed();
    tick_until_flag();
    `CHK(t >= tclks(0, 0) - 2 && t <= tclks(0, 0) + 1, 1'b1)
    `CHK(irq, 1'b1)
    `CHK(wd_rst, 1'b0)
    ien <= 0;
    repeat (2) @(posedge clk_in);
    `CHK(irq, 1'b0)
    wr(`WDU_OFF_CTRL, 32'h04);
    `CHK(flag, 1'b0)
    ien <= 1;
    // broken and lone feeds only flag an error in timer mode
    wr(`WDU_OFF_FEED1, 32'ha5);
    rd(`WDU_OFF_STATUS); `CHK(d[14:13], 2'b01)
    wr(`WDU_OFF_RELOAD, 32'h0);
    rd(`WDU_OFF_STATUS); `CHK(d[14:13], 2'b10)
    feed();
    wr(`WDU_OFF_FEED2, 32'h5a);
    rd(`WDU_OFF_STATUS); `CHK(d[14], 1'b1)
    `CHK(wd_rst, 1'b0)
    // watchdog mode: control write without a feed
    por(1, 0);
    wr(`WDU_OFF_CTRL, 32'he5);
    wr(`WDU_OFF_RELOAD, 32'hff);
    wait_rst(1, 4);
    wait_rst(0, 40);
    // bad key while powered down restarts the main oscillator
    pd <= 1;
    repeat (2) @(posedge clk_in);
    wr(`WDU_OFF_FEED1, 32'h11);
    wait_rst(1, 4);
    repeat (2) @(posedge clk_in);
    `CHK(osc_start, 1'b1)
    while (stable !== 1'b1) @(posedge clk_in);
    `CHK(wd_rst, 1'b1)
    pd <= 0;
    wait_rst(0, 40);
    // held values load only on the feed, then underflow resets
    wr(`WDU_OFF_RELOAD, 32'h0);
    wr(`WDU_OFF_CTRL, 32'h04);
    rd(`WDU_OFF_STATUS); `CHK(d[10:8], 3'h7)
    feed();
    // count right after the feed; a read first would hide ticks
    tick_until_flag();
    `CHK(t >= tclks(0, 0) - 2 && t <= tclks(0, 0) + 1, 1'b1)
    wait_rst(1, 3);
    rd(`WDU_OFF_STATUS); `CHK(d[12:8], 5'h08)
    // safety lock: forced source and run, one write only
    por(1, 1);
    rd(`WDU_OFF_STATUS); `CHK({d[17], d[12:11]}, 3'h7)
    wr(`WDU_OFF_CTRL, 32'h00);
    feed();
    rd(`WDU_OFF_STATUS); `CHK(d[12:8], 5'h18)
    wr(`WDU_OFF_CTRL, 32'he4);
    feed();
    rd(`WDU_OFF_STATUS); `CHK(d[10:8], 3'h0)
    results();
  end
endmodule // watchdog_timer_with_feed_tb
`default_nettype wire

// ### verification/wdu_osc_model.sv
// Purpose: watchdog oscillator and main oscillator of the far side
// Assumes: one clk_in domain for the model itself
// Notes: watchdog oscillator runs free, period six clk_in cycles
`timescale 1ns/1ps
`default_nettype none
module wdu_osc_model (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic osc_start_in,
  input wire logic powered_down_in,
  output logic wdosc_out,
  output logic osc_stable_out
);
  logic [2:0] div_ff;
  logic [4:0] warm_ff;
  // free-running watchdog oscillator
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      div_ff <= 3'h0;
      wdosc_out <= 1'b0;
    end else if (div_ff == 3'h2) begin
      div_ff <= 3'h0;
      wdosc_out <= ~wdosc_out;
    end else div_ff <= div_ff + 3'h1;
  end
  // main oscillator stops in power-down, warms up after a restart
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      warm_ff <= 5'h00;
      osc_stable_out <= 1'b1;
    end else if (powered_down_in && !osc_start_in) begin
      warm_ff <= 5'h00;
      osc_stable_out <= 1'b0;
    end else if (osc_start_in && !osc_stable_out) begin
      warm_ff <= warm_ff + 5'h01;
      if (warm_ff == 5'h13) osc_stable_out <= 1'b1;
    end
  end
endmodule // wdu_osc_model
`default_nettype wire

// ### verification/wdu_watchdog_unit_props.sv
// Purpose: port-level checks of the watchdog unit
// Assumes: config pins change only while resetn_in is low
// Notes: helper flops keep the last write address and data byte
`timescale 1ns/1ps
`default_nettype none
module wdu_props (
  input wire logic clk_in,
  input wire logic resetn_in,
  input wire logic reset_on_underflow_enable_in,
  input wire logic osc_stable_in,
  input wire logic interrupt_enable_in,
  input wire logic s_axi_awvalid_in,
  input wire logic s_axi_awready_out,
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_wvalid_in,
  input wire logic s_axi_wready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic s_axi_bvalid_out,
  input wire logic wd_reset_out,
  input wire logic osc_start_out,
  input wire logic irq_out,
  input wire logic timeout_flag_out
);
  logic [7:0] aw_q;
  logic [7:0] w_q;
  // capture at the handshake so the answer edge sees the write
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      aw_q <= 8'h00;
      w_q <= 8'h00;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) aw_q <= s_axi_awaddr_in;
      if (s_axi_wvalid_in && s_axi_wready_out) w_q <= s_axi_wdata_in[7:0];
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  //////////////////////////////////////////////////////////////////////
  property p_irq_gate;
    irq_out |-> timeout_flag_out && interrupt_enable_in;
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("irq without flag or enable");
  property p_no_rst_timer;
    !reset_on_underflow_enable_in |-> !wd_reset_out;
  endproperty
  a_no_rst_timer: assert property (p_no_rst_timer)
    else $error("reset in timer mode");
  property p_rst_min;
    $rose(wd_reset_out) |-> wd_reset_out[*2];
  endproperty
  a_rst_min: assert property (p_rst_min)
    else $error("reset pulse too short");
  property p_osc_hold;
    osc_start_out && !osc_stable_in |=> wd_reset_out;
  endproperty
  a_osc_hold: assert property (p_osc_hold)
    else $error("reset released before oscillator stable");
  property p_bad_feed;
    $rose(s_axi_bvalid_out) && reset_on_underflow_enable_in &&
      aw_q == 8'h08 && w_q != 8'ha5 |-> ##[0:3] wd_reset_out;
  endproperty
  a_bad_feed: assert property (p_bad_feed)
    else $error("bad first feed did not reset");
  property p_flag_clr;
    $rose(s_axi_bvalid_out) && !reset_on_underflow_enable_in &&
      aw_q == 8'h00 && !w_q[1] |-> ##[0:3] !timeout_flag_out;
  endproperty
  a_flag_clr: assert property (p_flag_clr)
    else $error("flag not cleared by zero write");
  property p_flag_irq;
    $rose(timeout_flag_out) && !reset_on_underflow_enable_in &&
      interrupt_enable_in |-> irq_out;
  endproperty
  a_flag_irq: assert property (p_flag_irq)
    else $error("timer underflow gave no irq");
  property p_uf_rst;
    $rose(timeout_flag_out) && reset_on_underflow_enable_in
      |-> ##[0:2] wd_reset_out;
  endproperty
  a_uf_rst: assert property (p_uf_rst)
    else $error("underflow did not reset");
  c_rst: cover property ($rose(wd_reset_out));
  c_irq: cover property ($rose(irq_out));
  c_osc: cover property ($rose(osc_start_out));
endmodule // wdu_props
bind wdu_watchdog_unit wdu_props u_wdu_props (.clk_in(clk_in),
  .resetn_in(resetn_in), .osc_stable_in(osc_stable_in),
  .reset_on_underflow_enable_in(reset_on_underflow_enable_in),
  .interrupt_enable_in(interrupt_enable_in),
  .s_axi_awvalid_in(s_axi_awvalid_in), .s_axi_awaddr_in(s_axi_awaddr_in),
  .s_axi_awready_out(s_axi_awready_out), .s_axi_wvalid_in(s_axi_wvalid_in),
  .s_axi_wready_out(s_axi_wready_out), .s_axi_wdata_in(s_axi_wdata_in),
  .s_axi_bvalid_out(s_axi_bvalid_out), .wd_reset_out(wd_reset_out),
  .osc_start_out(osc_start_out), .irq_out(irq_out),
  .timeout_flag_out(timeout_flag_out));
`default_nettype wire
